//--- design/segmap_pkg.sv
// package: constants and carriers for the data memory segment map
package segmap_pkg;
   // cpu register widths
   localparam int PC_W      = 15;
   localparam int PC_HI_W   = 7;
   localparam int PC_LO_W   = 8;
   // memory-mapped pointer, page and register addresses in the upper base segment
   localparam logic [7:0] ADDR_ALT_PTR   = 8'h00FC;
   localparam logic [7:0] ADDR_STACK_PTR = 8'h00FD;
   localparam logic [7:0] ADDR_RAM_PTR   = 8'h00FE;
   localparam logic [7:0] ADDR_PAGE_REG  = 8'h00FF;
   localparam logic [7:0] ADDR_REGS_LO   = 8'h00F0;
   // reset values and interrupt vector
   localparam logic [7:0] SP_RESET       = 8'h006F;
   localparam logic [7:0] PAGE_RESET     = 8'h0000;
   localparam logic [PC_W-1:0] PC_RESET  = 15'h0000;
   localparam logic [PC_W-1:0] IRQ_VECTOR = 15'h00FF;
   // ram windows (extended address)
   localparam logic [15:0] LOW_RAM_TOP   = 16'h006F;
   localparam logic [15:0] SEG1_LO       = 16'h0100;
   localparam logic [15:0] SEG1_HI       = 16'h017F;
   localparam int RAM_DEPTH              = 256;
   // security byte answers
   localparam logic [7:0] SEC_OPEN_VAL   = 8'h0000;
   localparam logic [7:0] SEC_LOCK_VAL   = 8'h00FF;
   localparam logic [7:0] SECURED_READ   = 8'h0000;

   // pointer selection for an access
   typedef enum logic [1:0] {
      SRC_DIRECT = 2'b00,
      SRC_RAM    = 2'b01,
      SRC_ALT    = 2'b10,
      SRC_STACK  = 2'b11
   } ptr_src_e;

   // post-access pointer adjustment
   typedef enum logic [1:0] {
      ADJ_NONE = 2'b00,
      ADJ_INC  = 2'b01,
      ADJ_DEC  = 2'b10
   } ptr_adj_e;

   // datapath operations
   typedef enum logic [3:0] {
      OP_NONE   = 4'b0000,
      OP_ADD    = 4'b0001,
      OP_SUB    = 4'b0010,
      OP_AND    = 4'b0011,
      OP_OR     = 4'b0100,
      OP_XOR    = 4'b0101,
      OP_SHR    = 4'b0110,
      OP_SHL    = 4'b0111,
      OP_LDI    = 4'b1000,
      OP_DSZ    = 4'b1001,
      OP_SETB   = 4'b1010,
      OP_CLRB   = 4'b1011,
      OP_TSTB   = 4'b1100,
      OP_TSTA   = 4'b1101,
      OP_LDA    = 4'b1110,
      OP_STA    = 4'b1111
   } dp_op_e;

   // one data access request from the execution unit
   typedef struct packed {
      logic       valid;
      ptr_src_e   src;
      ptr_adj_e   adj;
      logic [7:0] addr;
      dp_op_e     op;
      logic [2:0] bit_sel;
      logic [7:0] imm;
   } data_req_s;

   // program counter control
   typedef struct packed {
      logic            load;
      logic            step;
      logic            irq;
      logic [PC_W-1:0] target;
   } pc_ctl_s;

   // programmer-side request
   typedef struct packed {
      logic            prog_mode;
      logic            rd;
      logic            sec_rd;
      logic            sec_set;
      logic [PC_W-1:0] addr;
   } prog_req_s;
endpackage

//--- design/data_memory_segment_map.sv
// data memory segment map: pointers, segment extension, ram, security
module data_memory_segment_map
   import segmap_pkg::*;
(
   // clock and reset
   input  wire logic            i_clk,
   input  wire logic            i_rst,
   // execution datapath request
   input  wire data_req_s       i_req,
   input  wire pc_ctl_s         i_pc_ctl,
   // programmer port
   input  wire prog_req_s       i_prog,
   input  wire logic [7:0]      i_prog_rom_data,
   // results
   output logic [7:0]           o_rd_data,
   output logic                 o_rd_valid,
   output logic                 o_skip,
   output logic                 o_bit_test,
   output logic                 o_carry,
   output logic [15:0]          o_ext_addr,
   output logic                 o_ram_hit,
   output logic [7:0]           o_acc,
   output logic [PC_W-1:0]      o_pc,
   output logic [7:0]           o_data_page,
   output logic [7:0]           o_stack_ptr,
   // programmer answers
   output logic [7:0]           o_prog_data,
   output logic                 o_secured
);

   logic [7:0]       acc;
   logic [PC_W-1:0]  program_counter;
   logic [7:0]       ram_pointer;
   logic [7:0]       alt_ram_pointer;
   logic [7:0]       stack_pointer;
   logic [7:0]       data_page_reg;
   logic             secured;
   logic [7:0]       base_ram [0:RAM_DEPTH/2-1];
   logic [7:0]       seg1_ram [0:RAM_DEPTH/2-1];

   logic [7:0]       byte_addr;
   logic [15:0]      next_ext_addr;
   logic [7:0]       cur_val;
   logic [7:0]       next_val;
   logic             wr_en;
   logic [8:0]       alu_sum;
   logic             in_base;
   logic             in_seg1;

   // pointer step after use
   function automatic logic [7:0] adjust(input logic [7:0] p, input ptr_adj_e a);
      case (a)
         ADJ_INC: adjust = p + 8'h01;
         ADJ_DEC: adjust = p - 8'h01;
         default: adjust = p;
      endcase
   endfunction

   // base ram index: upper registers 0F0-0FF sit above the low bytes
   function automatic logic [6:0] base_index(input logic [15:0] e);
      base_index = e[6:0] | {e[7], 6'h00};
   endfunction

   // program counter halves
   wire [PC_HI_W-1:0] counter_high = program_counter[PC_W-1:PC_LO_W];
   wire [PC_LO_W-1:0] counter_low  = program_counter[PC_LO_W-1:0];

   // single-byte address selection
   always_comb begin
      case (i_req.src)
         SRC_RAM:   byte_addr = ram_pointer;
         SRC_ALT:   byte_addr = alt_ram_pointer;
         SRC_STACK: byte_addr = stack_pointer;
         default:   byte_addr = i_req.addr;
      endcase
   end

   // segment extension uses the register value before this access
   always_comb begin
      if (byte_addr[7] || i_req.src == SRC_STACK) begin
         next_ext_addr = {8'h00, byte_addr};
      end else begin
         next_ext_addr = {data_page_reg, byte_addr};
      end
   end

   // ram window decode
   assign in_base = (next_ext_addr <= LOW_RAM_TOP)
                    || (next_ext_addr[15:4] == {8'h00, ADDR_REGS_LO[7:4]});
   assign in_seg1 = (next_ext_addr >= SEG1_LO) && (next_ext_addr <= SEG1_HI);

   // current value at the addressed location
   always_comb begin
      if (next_ext_addr[15:8] == 8'h00 && byte_addr == ADDR_ALT_PTR) begin
         cur_val = alt_ram_pointer;
      end else if (next_ext_addr[15:8] == 8'h00 && byte_addr == ADDR_STACK_PTR) begin
         cur_val = stack_pointer;
      end else if (next_ext_addr[15:8] == 8'h00 && byte_addr == ADDR_RAM_PTR) begin
         cur_val = ram_pointer;
      end else if (next_ext_addr[15:8] == 8'h00 && byte_addr == ADDR_PAGE_REG) begin
         cur_val = data_page_reg;
      end else if (in_base) begin
         cur_val = base_ram[base_index(next_ext_addr)];
      end else if (in_seg1) begin
         cur_val = seg1_ram[next_ext_addr[6:0]];
      end else begin
         cur_val = 8'h00;
      end
   end

   // single-cycle alu and bit operations
   always_comb begin
      alu_sum  = 9'h000;
      next_val = cur_val;
      wr_en    = 1'b0;
      case (i_req.op)
         OP_ADD:  alu_sum = {1'b0, acc} + {1'b0, cur_val};
         OP_SUB:  alu_sum = {1'b0, acc} - {1'b0, cur_val};
         OP_LDI: begin
            next_val = i_req.imm;
            wr_en    = 1'b1;
         end
         OP_DSZ: begin
            next_val = cur_val - 8'h01;
            wr_en    = 1'b1;
         end
         OP_SETB: begin
            next_val = cur_val | (8'h01 << i_req.bit_sel);
            wr_en    = 1'b1;
         end
         OP_CLRB: begin
            next_val = cur_val & ~(8'h01 << i_req.bit_sel);
            wr_en    = 1'b1;
         end
         OP_STA: begin
            next_val = acc;
            wr_en    = 1'b1;
         end
         default: alu_sum = 9'h000;
      endcase
   end

   // accumulator and flags
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         acc     <= 8'h00;
         o_carry <= 1'b0;
      end else if (i_req.valid) begin
         case (i_req.op)
            OP_ADD, OP_SUB: begin
               acc     <= alu_sum[7:0];
               o_carry <= alu_sum[8];
            end
            OP_AND:  acc <= acc & cur_val;
            OP_OR:   acc <= acc | cur_val;
            OP_XOR:  acc <= acc ^ cur_val;
            OP_SHR: begin
               acc     <= {o_carry, acc[7:1]};
               o_carry <= acc[0];
            end
            OP_SHL: begin
               acc     <= {acc[6:0], o_carry};
               o_carry <= acc[7];
            end
            OP_LDA:  acc <= cur_val;
            default: acc <= acc;
         endcase
      end
   end

   // program counter with interrupt vector
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         program_counter <= PC_RESET;
      end else if (i_pc_ctl.irq) begin
         program_counter <= IRQ_VECTOR;
      end else if (i_pc_ctl.load) begin
         program_counter <= i_pc_ctl.target;
      end else if (i_pc_ctl.step) begin
         program_counter <= {counter_high, counter_low} + 15'h0001;
      end
   end

   // pointer and segment registers; memory-mapped write beats post-adjust
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         stack_pointer   <= SP_RESET;
         data_page_reg   <= PAGE_RESET;
         ram_pointer     <= 8'h00;
         alt_ram_pointer <= 8'h00;
      end else if (i_req.valid) begin
         if (i_req.src == SRC_RAM) begin
            ram_pointer <= adjust(ram_pointer, i_req.adj);
         end
         if (i_req.src == SRC_ALT) begin
            alt_ram_pointer <= adjust(alt_ram_pointer, i_req.adj);
         end
         if (i_req.src == SRC_STACK) begin
            stack_pointer <= adjust(stack_pointer, i_req.adj);
         end
         if (wr_en && next_ext_addr[15:8] == 8'h00) begin
            case (byte_addr)
               ADDR_ALT_PTR:   alt_ram_pointer <= next_val;
               ADDR_STACK_PTR: stack_pointer   <= next_val;
               ADDR_RAM_PTR:   ram_pointer     <= next_val;
               ADDR_PAGE_REG:  data_page_reg   <= next_val;
               default:        ;
            endcase
         end
      end
   end

   // ram arrays, no reset
   always_ff @(posedge i_clk) begin
      if (i_req.valid && wr_en && in_base) begin
         base_ram[base_index(next_ext_addr)] <= next_val;
      end
      if (i_req.valid && wr_en && in_seg1) begin
         seg1_ram[next_ext_addr[6:0]] <= next_val;
      end
   end

   // access results
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_rd_data  <= 8'h00;
         o_rd_valid <= 1'b0;
         o_skip     <= 1'b0;
         o_bit_test <= 1'b0;
         o_ext_addr <= 16'h0000;
         o_ram_hit  <= 1'b0;
      end else begin
         o_rd_valid <= i_req.valid;
         o_rd_data  <= i_req.valid ? cur_val : 8'h00;
         o_ext_addr <= next_ext_addr;
         o_ram_hit  <= i_req.valid && (in_base || in_seg1);
         o_skip     <= i_req.valid && i_req.op == OP_DSZ && next_val == 8'h00;
         if (i_req.valid && i_req.op == OP_TSTB) begin
            o_bit_test <= cur_val[i_req.bit_sel];
         end else if (i_req.valid && i_req.op == OP_TSTA) begin
            o_bit_test <= acc[i_req.bit_sel];
         end
      end
   end

   // security byte, reachable only from programming mode
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         secured     <= 1'b0;
         o_prog_data <= 8'h00;
      end else if (i_prog.prog_mode) begin
         if (i_prog.sec_set) begin
            secured <= 1'b1;
         end
         if (i_prog.sec_rd) begin
            o_prog_data <= secured ? SEC_LOCK_VAL : SEC_OPEN_VAL;
         end else if (i_prog.rd) begin
            o_prog_data <= secured ? SECURED_READ : i_prog_rom_data;
         end
      end
   end

   // mirrored state outputs
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_acc       <= 8'h00;
         o_pc        <= PC_RESET;
         o_data_page <= PAGE_RESET;
         o_stack_ptr <= SP_RESET;
         o_secured   <= 1'b0;
      end else begin
         o_acc       <= acc;
         o_pc        <= program_counter;
         o_data_page <= data_page_reg;
         o_stack_ptr <= stack_pointer;
         o_secured   <= secured;
      end
   end
endmodule

//--- test/segmap_chk.sv
// checker: port-level properties of the segment map
module segmap_chk
   import segmap_pkg::*;
(
   // clock and reset
   input wire logic            i_clk,
   input wire logic            i_rst,
   // requests
   input wire data_req_s       i_req,
   input wire pc_ctl_s         i_pc_ctl,
   input wire prog_req_s       i_prog,
   // answers
   input wire logic [7:0]      o_rd_data,
   input wire logic            o_rd_valid,
   input wire logic            o_ram_hit,
   input wire logic [15:0]     o_ext_addr,
   input wire logic [PC_W-1:0] o_pc,
   input wire logic [7:0]      o_data_page,
   input wire logic [7:0]      o_stack_ptr,
   input wire logic [7:0]      o_prog_data,
   input wire logic            o_secured
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);
   // answers follow requests one cycle later
   a_answer_pulse: assert property (
      !$past(i_rst) |-> o_rd_valid == $past(i_req.valid)) else $error("answer pulse wrong");
   a_upper_direct: assert property (
      i_req.valid && i_req.src == SRC_DIRECT && i_req.addr[7]
      |=> o_ext_addr == {8'h00, $past(i_req.addr)}) else $error("upper half extended");
   a_lower_extend: assert property (
      i_req.valid && i_req.src == SRC_DIRECT && !i_req.addr[7]
      |=> o_ext_addr == {o_data_page, 1'b0, $past(i_req.addr[6:0])}) else $error("bad extension");
   a_stack_base: assert property (
      i_req.valid && i_req.src == SRC_STACK
      |=> o_ext_addr == {8'h00, o_stack_ptr}) else $error("stack not in segment 0");
   a_stack_keeps_seg: assert property (
      i_req.valid && i_req.src == SRC_STACK |-> ##2 $stable(o_data_page))
      else $error("stack access moved segment");
   a_ram_decode: assert property (
      o_rd_valid |-> o_ram_hit == (o_ext_addr <= LOW_RAM_TOP
      || o_ext_addr inside {[16'h00f0:SEG1_HI]})) else $error("ram decode wrong");
   a_gap_reads_zero: assert property (
      o_rd_valid && o_ext_addr inside {[16'h0070:16'h007f]} |-> o_rd_data == 8'h00)
      else $error("gap returned data");
   a_irq_vector: assert property (
      i_pc_ctl.irq |-> ##2 o_pc == IRQ_VECTOR) else $error("irq vector wrong");
   a_reset_values: assert property (
      disable iff (1'b0) i_rst |=> o_stack_ptr == SP_RESET && o_data_page == PAGE_RESET)
      else $error("reset values wrong");
   a_sec_answer: assert property (
      i_prog.prog_mode && i_prog.sec_rd && !i_prog.sec_set
      |=> o_prog_data == (o_secured ? SEC_LOCK_VAL : SEC_OPEN_VAL)) else $error("sec byte wrong");
   a_secured_rom: assert property (
      i_prog.prog_mode && i_prog.rd |=> !o_secured || o_prog_data == SECURED_READ)
      else $error("secured read leaked");
   a_prog_gated: assert property (
      !i_prog.prog_mode |=> $stable(o_prog_data)) else $error("answer outside prog mode");
endmodule

bind data_memory_segment_map segmap_chk u_chk (.i_clk, .i_rst, .i_req, .i_pc_ctl, .i_prog,
   .o_rd_data, .o_rd_valid, .o_ram_hit, .o_ext_addr, .o_pc, .o_data_page, .o_stack_ptr,
   .o_prog_data, .o_secured);

//--- test/cpu_model.sv
// partner: execution unit issuing data requests
module cpu_model
   import segmap_pkg::*;
(
   // clock
   input  wire logic i_clk,
   // request to the segment map
   output data_req_s o_req
);
   timeunit 1ns;
   timeprecision 1ps;
   initial o_req = '0;
   // one single-byte request, held through its taking edge
   task automatic op(input ptr_src_e s, input ptr_adj_e j, input logic [7:0] a,
                     input dp_op_e o, input logic [2:0] b, input logic [7:0] d);
      o_req = {1'b1, s, j, a, o, b, d};
      @(posedge i_clk);
      #1;
   endtask
   // idle cycles; stale fields inverted so nothing lingers
   task automatic idle(input int n);
      o_req = {1'b0, ~o_req[$bits(data_req_s)-2:0]};
      repeat (n) @(posedge i_clk);
      #1;
   endtask
endmodule

//--- test/data_memory_segment_map_bench.sv
// testbench: segment map under random and corner traffic
module data_memory_segment_map_bench
   import segmap_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic            i_clk = 1'b0;
   logic            i_rst = 1'b1;
   pc_ctl_s         pc    = '0;
   prog_req_s       pg    = '0;
   logic [7:0]      rom   = 8'h00;
   data_req_s       req;
   logic [7:0]      rd, page, sp, pdat, s, a, v, ac;
   logic [15:0]     ext;
   logic [PC_W-1:0] pcv, tg;
   logic [2:0]      b;
   logic            skip, bt, hit, sec, cy;
   logic [7:0]      cor [4] = '{8'h6f, 8'h70, 8'h7f, 8'h80};
   int              n_errors = 0;
   int              n_compared = 0;
   always #4 i_clk = ~i_clk;
   cpu_model cpu (.i_clk(i_clk), .o_req(req));
   data_memory_segment_map DUT (.i_clk(i_clk), .i_rst(i_rst), .i_req(req), .i_pc_ctl(pc),
      .i_prog(pg), .i_prog_rom_data(rom), .o_rd_data(rd), .o_rd_valid(), .o_skip(skip),
      .o_bit_test(bt), .o_carry(cy), .o_ext_addr(ext), .o_ram_hit(hit), .o_acc(ac),
      .o_pc(pcv), .o_data_page(page), .o_stack_ptr(sp), .o_prog_data(pdat),
      .o_secured(sec));
   // compare and count
   task chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task summarize();
      if (n_errors == 0 && n_compared > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // expected extended address and ram decode
   function logic [15:0] extf(input logic [7:0] sg, input logic [7:0] ad);
      return ad[7] ? {8'h00, ad} : {sg, 1'b0, ad[6:0]};
   endfunction
   function logic hitf(input logic [15:0] e);
      return e <= 16'h006f || (e >= 16'h00f0 && e <= 16'h017f);
   endfunction
   task d(input dp_op_e o, input logic [7:0] ad, input logic [7:0] im);
      cpu.op(SRC_DIRECT, ADJ_NONE, ad, o, 3'd0, im);
   endtask
   task prg(input logic md, input logic r, input logic sr, input logic ss);
      pg = {md, r, sr, ss, 15'($urandom)};
      @(posedge i_clk);
      #1;
   endtask
   // hang guard
   initial begin
      #200000;
      n_errors++;
      summarize();
   end
   initial begin
      s = 8'($urandom(32'h3f43));
      repeat (6) @(posedge i_clk);
      #1 i_rst = 1'b0;
      chk({8'h00, sp}, {8'h00, SP_RESET});
      chk({8'h00, page}, {8'h00, PAGE_RESET});
      // segment write then access back to back, corners first
      for (int i = 0; i < 40; i++) begin
         s = (i < 8) ? 8'(i % 2) : 8'($urandom);
         a = (i < 8) ? cor[i / 2] : 8'($urandom);
         d(OP_LDI, ADDR_PAGE_REG, s);
         d(OP_LDA, a, 8'h00);
         chk(ext, extf(s, a));
         chk({15'h0, hit}, {15'h0, hitf(extf(s, a))});
         if (!a[7] && !hitf(extf(s, a))) chk({8'h00, rd}, 16'h0000);
      end
      // store in segment 1, shadow store in segment 2, read back
      v = 8'($urandom);
      d(OP_LDI, ADDR_REGS_LO, v);
      d(OP_LDA, ADDR_REGS_LO, 8'h00);
      d(OP_LDI, ADDR_PAGE_REG, 8'h01);
      d(OP_STA, 8'h10, 8'h00);
      chk(ext, 16'h0110);
      d(OP_LDI, ADDR_REGS_LO, ~v);
      d(OP_LDA, ADDR_REGS_LO, 8'h00);
      d(OP_LDI, ADDR_PAGE_REG, 8'h02);
      d(OP_STA, 8'h10, 8'h00);
      d(OP_LDI, ADDR_PAGE_REG, 8'h01);
      d(OP_LDA, 8'h10, 8'h00);
      chk({8'h00, rd}, {8'h00, v});
      // decrement and skip on a register byte
      for (int k = 1; k < 3; k++) begin
         d(OP_LDI, 8'hf1, 8'(k));
         d(OP_DSZ, 8'hf1, 8'h00);
         chk({15'h0, skip}, {15'h0, k == 1});
      end
      // set, clear, test one bit; test accumulator bit
      b = 3'($urandom);
      d(OP_LDI, 8'hf2, 8'h00);
      for (int k = 0; k < 2; k++) begin
         cpu.op(SRC_DIRECT, ADJ_NONE, 8'hf2, k ? OP_CLRB : OP_SETB, b, 8'h00);
         cpu.op(SRC_DIRECT, ADJ_NONE, 8'hf2, OP_TSTB, b, 8'h00);
         chk({15'h0, bt}, {15'h0, k == 0});
      end
      cpu.op(SRC_DIRECT, ADJ_NONE, 8'h00, OP_TSTA, b, 8'h00);
      chk({15'h0, bt}, {15'h0, v[b]});
      // add with carry out, seen on the accumulator mirror
      s = 8'($urandom) | 8'h80;
      a = 8'($urandom) | 8'h80;
      d(OP_LDI, 8'hf3, s);
      d(OP_LDI, 8'hf4, a);
      d(OP_LDA, 8'hf3, 8'h00);
      d(OP_ADD, 8'hf4, 8'h00);
      cpu.idle(1);
      chk({7'h00, cy, ac}, {7'h00, 9'({1'b0, s} + {1'b0, a})});
      // stack access in segment 5 stays in segment 0
      d(OP_LDI, ADDR_PAGE_REG, 8'h05);
      cpu.op(SRC_STACK, ADJ_DEC, 8'h00, OP_LDA, 3'd0, 8'h00);
      chk(ext, 16'h006f);
      cpu.idle(1);
      chk({8'h00, sp}, 16'h006e);
      chk({8'h00, page}, 16'h0005);
      // indexed accesses with post step, pointers read back through the map
      s = 8'($urandom);
      a = 8'($urandom);
      d(OP_LDI, ADDR_RAM_PTR, s);
      d(OP_LDI, ADDR_ALT_PTR, a);
      cpu.op(SRC_RAM, ADJ_INC, 8'h00, OP_LDA, 3'd0, 8'h00);
      chk(ext, extf(8'h05, s));
      cpu.op(SRC_ALT, ADJ_DEC, 8'h00, OP_LDA, 3'd0, 8'h00);
      chk(ext, extf(8'h05, a));
      d(OP_LDA, ADDR_RAM_PTR, 8'h00);
      chk({8'h00, rd}, {8'h00, s + 8'h01});
      d(OP_LDA, ADDR_ALT_PTR, 8'h00);
      chk({8'h00, rd}, {8'h00, a - 8'h01});
      // counter load, then interrupt, then step
      tg = 15'($urandom);
      for (int k = 0; k < 3; k++) begin
         pc = {k == 0, k == 2, k == 1, tg};
         @(posedge i_clk);
         #1 pc = '0;
         @(posedge i_clk);
         #1 chk({1'b0, pcv}, {1'b0, k == 0 ? tg : IRQ_VECTOR + 15'(k - 1)});
      end
      // programmer port: open, gated, secured
      rom = 8'($urandom) | 8'h01;
      prg(1'b1, 1'b1, 1'b0, 1'b0);
      chk({8'h00, pdat}, {8'h00, rom});
      prg(1'b0, 1'b0, 1'b0, 1'b1);
      prg(1'b1, 1'b0, 1'b1, 1'b0);
      chk({8'h00, pdat}, {8'h00, SEC_OPEN_VAL});
      chk({15'h0, sec}, 16'h0000);
      // array read and checked above, only now secured
      prg(1'b1, 1'b0, 1'b0, 1'b1);
      prg(1'b1, 1'b0, 1'b1, 1'b0);
      chk({8'h00, pdat}, {8'h00, SEC_LOCK_VAL});
      chk({15'h0, sec}, 16'h0001);
      prg(1'b1, 1'b1, 1'b0, 1'b0);
      chk({8'h00, pdat}, {8'h00, SECURED_READ});
      prg(1'b0, 1'b0, 1'b0, 1'b0);
      summarize();
   end
endmodule
